// ==== core/dpio_core.sv ====
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
module dpio_core (
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [dpio_pkg::ADDR_W-1:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic irq, // Capture interrupt, level
	input wire dpio_pkg::dpio_trig_t trig_pin, // Trigger pins
	input wire dpio_pkg::dpio_limit_t limit_pin, // Limit pins
	input wire logic [31:0] axis_position, // Actual position
	input wire logic [15:0] setpoint_one, // Converted setpoint 1
	input wire logic [15:0] setpoint_two, // Converted setpoint 2
	input wire logic [1:0] mon_mapped, // Monitor signal mapped
	input wire logic [15:0] mon_signal_one, // Mapped signal 1
	input wire logic [15:0] mon_signal_two, // Mapped signal 2
	input wire logic [19:0][7:0] dout_free, // Output free usable
	input wire logic [19:0][7:0] dout_signal, // Selected signals
	output logic [23:0] out_pins, // Physical outputs
	output logic [15:0] control_word, // Drive control word
	output logic [15:0] monitor_output_one, // Monitor 1 value
	output logic [15:0] monitor_output_two, // Monitor 2 value
	output logic trace_start // Trace start pulse
);
	// Bus address split: register index and array element
	// Element zero addresses a simple variable
	wire [15:0] idx = paddr[dpio_pkg::IDX_LSB +: 16];
	wire [4:0] sub = paddr[dpio_pkg::SUB_LSB +: 5];
	// Arrays are numbered from one; storage from zero
	wire [4:0] sub_m1 = sub - dpio_pkg::SUB_SP_ONE;

	// Bus phases
	// Setup cycle launches the registered answer
	wire setup = psel & ~penable;
	// Write lands only at the edge that sees ready high
	wire wr_go = psel & penable & pready & pwrite;

	// Element range checks per array
	wire in_aout = sub != dpio_pkg::SUB_NONE && sub <= dpio_pkg::AOUT_N;
	wire in_ain = sub != dpio_pkg::SUB_NONE && sub <= dpio_pkg::AIN_N;
	wire in_dout = sub != dpio_pkg::SUB_NONE && sub <= dpio_pkg::DOUT_N;
	// Reserved output elements: readable as their output state, never written
	wire rsv_a = sub >= dpio_pkg::RSV_A_LO && sub <= dpio_pkg::RSV_A_HI;
	wire rsv_b = sub >= dpio_pkg::RSV_B_LO && sub <= dpio_pkg::RSV_B_HI;
	wire dout_rsv = rsv_a || rsv_b;
	// Only the three event selection elements exist
	wire mode_meas = sub == dpio_pkg::SUB_MODE_MEAS;
	wire mode_fast = sub == dpio_pkg::SUB_MODE_FAST;
	wire mode_trace = sub == dpio_pkg::SUB_MODE_TRACE;
	wire in_mode = mode_meas || mode_fast || mode_trace;

	// Write strobes, one per writable register
	// Each needs a valid element, else the write is refused
	wire w_aout = wr_go && idx == dpio_pkg::IDX_AOUT && in_aout;
	wire w_dout = wr_go && idx == dpio_pkg::IDX_DOUT && in_dout && !dout_rsv;
	wire w_mask = wr_go && idx == dpio_pkg::IDX_MASK && sub == dpio_pkg::SUB_NONE;
	wire w_mode = wr_go && idx == dpio_pkg::IDX_MODE && in_mode;
	wire w_ien = wr_go && idx == dpio_pkg::IDX_IEN && sub == dpio_pkg::SUB_NONE;
	wire w_iclr = wr_go && idx == dpio_pkg::IDX_ICLR && sub == dpio_pkg::SUB_NONE;

	// Registers
	logic [3:0][15:0] aout;
	logic [19:0][7:0] dout_wr;
	logic [19:0][7:0] dout_state;
	logic [15:0] mask;
	logic [15:0] done;
	logic [2:0][15:0] mode;
	logic [31:0] pos_one;
	logic [31:0] pos_two;
	logic [15:0] istat;
	logic [15:0] ien;
	logic [2:0] lim_s1;
	logic [2:0] lim_s2;
	logic [2:0] trg_s1;
	logic [2:0] trg_s2;
	logic [2:0] trg_s3;
	// Per-function capture results, one bit per engine
	// Nets, since each engine drives only its own bit
	wire [2:0] lat1;
	wire [2:0] lat2;
	wire [2:0] fin;
	logic [15:0] set_bits;

	// Limit word, negative and positive inverted for openers
	wire [31:0] limit_word = {29'h0, lim_s2[dpio_pkg::LIM_PRE],
		~lim_s2[dpio_pkg::LIM_POS], ~lim_s2[dpio_pkg::LIM_NEG]};

	// Analog inputs: two converted setpoints, rest read zero
	// Elements beyond two have no converter behind them
	wire [15:0] ain_val = sub == dpio_pkg::SUB_SP_ONE ? setpoint_one :
		sub == dpio_pkg::SUB_SP_TWO ? setpoint_two : 16'h0000;

	// Event selection element to engine number
	wire [2:0] mode_sel = mode_meas ? 3'h0 : mode_fast ? 3'h1 : 3'h2;

	// Read selection and address check
	wire [31:0] rd_data =
		idx == dpio_pkg::IDX_AOUT ? {{16{aout[sub_m1[1:0]][15]}}, aout[sub_m1[1:0]]} :
		idx == dpio_pkg::IDX_AIN ? {{16{ain_val[15]}}, ain_val} :
		idx == dpio_pkg::IDX_DOUT ? {24'h0, dout_state[sub_m1]} :
		idx == dpio_pkg::IDX_MASK ? {16'h0, mask} :
		idx == dpio_pkg::IDX_DONE ? {16'h0, done} :
		idx == dpio_pkg::IDX_LIMIT ? limit_word :
		idx == dpio_pkg::IDX_MODE ? {{16{mode[mode_sel][15]}}, mode[mode_sel]} :
		idx == dpio_pkg::IDX_POS1 ? pos_one :
		idx == dpio_pkg::IDX_POS2 ? pos_two :
		idx == dpio_pkg::IDX_ISTAT ? {16'h0, istat} :
		idx == dpio_pkg::IDX_IEN ? {16'h0, ien} : 32'h0;
	wire simple = sub == dpio_pkg::SUB_NONE;
	wire ok_rd =
		idx == dpio_pkg::IDX_AOUT ? in_aout :
		idx == dpio_pkg::IDX_AIN ? in_ain :
		idx == dpio_pkg::IDX_DOUT ? in_dout :
		idx == dpio_pkg::IDX_MODE ? in_mode :
		idx == dpio_pkg::IDX_MASK || idx == dpio_pkg::IDX_DONE ? simple :
		idx == dpio_pkg::IDX_LIMIT || idx == dpio_pkg::IDX_POS1 ? simple :
		idx == dpio_pkg::IDX_POS2 || idx == dpio_pkg::IDX_ISTAT ? simple :
		idx == dpio_pkg::IDX_IEN ? simple : 1'b0;
	wire ok_wr =
		idx == dpio_pkg::IDX_AOUT ? in_aout :
		idx == dpio_pkg::IDX_DOUT ? in_dout && !dout_rsv :
		idx == dpio_pkg::IDX_MODE ? in_mode :
		idx == dpio_pkg::IDX_MASK || idx == dpio_pkg::IDX_IEN ? simple :
		idx == dpio_pkg::IDX_ICLR ? simple : 1'b0;
	wire bad = pwrite ? !ok_wr : !ok_rd;

	// APB answer: one access cycle, data and error registered in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & bad;
			prdata <= (setup && !pwrite && !bad) ? rd_data : 32'h0;
		end
	end

	// Re-arm on 0 to 1 of a mask bit clears status
	// A 1 written over a 1 does not re-arm
	wire [15:0] rearm = w_mask ? pwdata[15:0] & ~mask : 16'h0;
	// Set wins over a re-arm in the same cycle
	wire [15:0] next_done = set_bits | (done & ~rearm);

	// Interrupt status: write one to clear, set wins
	wire [15:0] iclr = w_iclr ? pwdata[15:0] : 16'h0;
	wire [15:0] next_istat = set_bits | (istat & ~iclr);
	// Enable seen as written this cycle, so irq has one lag only
	wire [15:0] next_ien = w_ien ? pwdata[15:0] : ien;
	wire next_irq = |(next_istat & next_ien);

	// Mask, status and interrupt registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= dpio_pkg::MASK_RST;
			done <= 16'h0000;
			istat <= 16'h0000;
			ien <= 16'h0000;
			irq <= 1'b0;
		end else begin
			if (w_mask) mask <= pwdata[15:0];
			done <= next_done;
			istat <= next_istat;
			ien <= next_ien;
			irq <= next_irq;
		end
	end

	// Limit synchroniser, two stages before any logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lim_s1 <= 3'h0;
			lim_s2 <= 3'h0;
		end else begin
			lim_s1 <= limit_pin;
			lim_s2 <= lim_s1;
		end
	end

	// Trigger synchroniser plus one stage for edge detect
	// Third stage only delays; edges come from stages two and three
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trg_s1 <= 3'h0;
			trg_s2 <= 3'h0;
			trg_s3 <= 3'h0;
		end else begin
			trg_s1 <= trig_pin;
			trg_s2 <= trg_s1;
			trg_s3 <= trg_s2;
		end
	end

	// One capture engine per trigger function
	// Engine k owns mask and status bit 2k
	// Pulse modes wait in the middle state for the trailing edge
	// Clearing the mask bit aborts a pulse half way
	genvar k;
	generate
		for (k = 0; k < dpio_pkg::FN_N; k++) begin : g_fn
			localparam int B = 2 * k;
			dpio_pkg::dpio_cap_t st;
			dpio_pkg::dpio_cap_t next_st;
			wire rise = trg_s2[k] & ~trg_s3[k];
			wire fall = ~trg_s2[k] & trg_s3[k];
			wire neg = mode[k] == dpio_pkg::MODE_NEG_EDGE ||
				mode[k] == dpio_pkg::MODE_NEG_PULSE;
			wire pulse = mode[k] == dpio_pkg::MODE_POS_PULSE ||
				mode[k] == dpio_pkg::MODE_NEG_PULSE;
			wire lead = neg ? fall : rise;
			wire trail = neg ? rise : fall;
			wire armed = mask[B] & ~done[B];
			wire first = st == dpio_pkg::CAP_IDLE && armed && lead;
			wire second = st == dpio_pkg::CAP_MID && armed && trail;
			assign lat1[k] = first;
			assign lat2[k] = second;
			assign fin[k] = (first && !pulse) || second;
			assign next_st = !armed ? dpio_pkg::CAP_IDLE :
				(first && pulse) ? dpio_pkg::CAP_MID :
				second ? dpio_pkg::CAP_IDLE : st;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					st <= dpio_pkg::CAP_IDLE;
				end else begin
					st <= next_st;
				end
			end
		end
	endgenerate

	// Status bits set on completion
	assign set_bits = {11'h0, fin[2], 1'b0, fin[1], 1'b0, fin[0]};

	// Position latches; same edge as status for the final latch
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_one <= 32'h0;
			pos_two <= 32'h0;
			trace_start <= 1'b0;
		end else begin
			if (lat1[0] || lat1[1]) pos_one <= axis_position;
			if (lat2[1]) pos_two <= axis_position;
			trace_start <= fin[2];
		end
	end

	// Event selection per function
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode <= {3{dpio_pkg::MODE_POS_EDGE}};
		end else if (w_mode) begin
			mode[mode_sel] <= pwdata[15:0];
		end
	end

	// Analog output words and monitor drive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aout <= '0;
			monitor_output_one <= 16'h0000;
			monitor_output_two <= 16'h0000;
		end else begin
			if (w_aout) aout[sub_m1[1:0]] <= pwdata[15:0];
			monitor_output_one <= mon_mapped[0] ? mon_signal_one : aout[0];
			monitor_output_two <= mon_mapped[1] ? mon_signal_two : aout[1];
		end
	end

	// Digital outputs: written bits only where free
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_wr <= '0;
			dout_state <= '0;
			control_word <= 16'h0000;
			out_pins <= 24'h0;
		end else begin
			if (w_dout) dout_wr[sub_m1] <= pwdata[7:0];
			for (int i = 0; i < dpio_pkg::DOUT_CNT; i++) begin
				dout_state[i] <= (dout_free[i] & dout_wr[i]) |
					(~dout_free[i] & dout_signal[i]);
			end
			control_word <= {dout_state[dpio_pkg::CW_HI], dout_state[dpio_pkg::CW_LO]};
			out_pins <= dout_state[dpio_pkg::PIN_ELEMS-1:0];
		end
	end
endmodule
`default_nettype wire

// ==== core/dpio_pkg.sv ====
package dpio_pkg;
	// Register indexes; byte address = 4 * index, element in paddr[22:18]
	localparam logic [15:0] IDX_AOUT = 16'h5F50;
	localparam logic [15:0] IDX_AIN = 16'h5F52;
	localparam logic [15:0] IDX_DOUT = 16'h5F54;
	localparam logic [15:0] IDX_MASK = 16'h5F7F;
	localparam logic [15:0] IDX_DONE = 16'h5F80;
	localparam logic [15:0] IDX_LIMIT = 16'h60FD;
	localparam logic [15:0] IDX_MODE = 16'h5FB1;
	localparam logic [15:0] IDX_POS1 = 16'h5F1C;
	localparam logic [15:0] IDX_POS2 = 16'h5E95;
	localparam logic [15:0] IDX_ISTAT = 16'h5FF0;
	localparam logic [15:0] IDX_IEN = 16'h5FF1;
	localparam logic [15:0] IDX_ICLR = 16'h5FF2;
	localparam int ADDR_W = 23;
	localparam int IDX_LSB = 2;
	localparam int SUB_LSB = 18;
	localparam logic [4:0] SUB_NONE = 5'h00;
	// Analog input elements with a converter behind them
	localparam logic [4:0] SUB_SP_ONE = 5'h01;
	localparam logic [4:0] SUB_SP_TWO = 5'h02;
	// Event selection elements per trigger function
	localparam logic [4:0] SUB_MODE_MEAS = 5'h01;
	localparam logic [4:0] SUB_MODE_FAST = 5'h03;
	localparam logic [4:0] SUB_MODE_TRACE = 5'h05;
	// Reserved output elements, refused on write
	localparam logic [4:0] RSV_A_LO = 5'h04;
	localparam logic [4:0] RSV_A_HI = 5'h07;
	localparam logic [4:0] RSV_B_LO = 5'h0C;
	localparam logic [4:0] RSV_B_HI = 5'h0E;
	// Array sizes and special elements
	localparam logic [4:0] AOUT_N = 5'h04;
	localparam logic [4:0] AIN_N = 5'h0C;
	localparam logic [4:0] DOUT_N = 5'h14;
	localparam int DOUT_CNT = 20;
	localparam int CW_LO = 9;
	localparam int CW_HI = 10;
	localparam int PIN_ELEMS = 3;
	// Trigger functions: mask/status bit of each
	localparam int FN_N = 3;
	localparam int BIT_MEAS = 0;
	localparam int BIT_FAST = 2;
	localparam int BIT_TRACE = 4;
	localparam logic [15:0] MASK_RST = 16'h0000;
	// Event selection codes
	localparam logic [15:0] MODE_POS_EDGE = 16'h0000;
	localparam logic [15:0] MODE_NEG_EDGE = 16'hFFFF;
	localparam logic [15:0] MODE_POS_PULSE = 16'hFFFE;
	localparam logic [15:0] MODE_NEG_PULSE = 16'hFFFD;
	// Limit word bit positions
	localparam int LIM_NEG = 0;
	localparam int LIM_POS = 1;
	localparam int LIM_PRE = 2;

	typedef enum logic [1:0] {
		CAP_IDLE = 2'b00,
		CAP_MID = 2'b01
	} dpio_cap_t;

	// Trigger pins, one per capture function
	typedef struct packed {
		logic trace;
		logic fast;
		logic meas;
	} dpio_trig_t;

	// Limit and pre-pulse pins
	typedef struct packed {
		logic pre;
		logic pos;
		logic neg;
	} dpio_limit_t;
endpackage

// ==== verification/dpio_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpio_monitor (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [1:0] mon_mapped, // Monitor mapping
	input wire logic [15:0] mon_signal_one, // Mapped signal 1
	input wire logic [15:0] mon_signal_two, // Mapped signal 2
	input wire logic [15:0] monitor_output_one, // Monitor 1
	input wire logic [15:0] monitor_output_two, // Monitor 2
	input wire logic [15:0] control_word, // Control word
	input wire logic trace_start // Trace pulse
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus phases
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		pready && psel && penable;
	endsequence
	// Bus answer timing
	a_ready_after_setup: assert property (s_setup |=> s_answer)
		else $error("setup not answered next cycle");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held too long");
	a_err_with_ready: assert property (pslverr |-> s_answer)
		else $error("error outside answer");
	a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside answer");
	// Capture and outputs
	a_trace_once: assert property (trace_start |=> !trace_start [*4])
		else $error("trace started again");
	a_reset_quiet: assert property ($rose(presetn) |-> control_word == 16'h0 && !trace_start)
		else $error("outputs not clear after reset");
	a_mon_one_mapped: assert property (mon_mapped[0] |=> monitor_output_one == $past(mon_signal_one))
		else $error("monitor 1 ignores mapped signal");
	a_mon_two_mapped: assert property (mon_mapped[1] |=> monitor_output_two == $past(mon_signal_two))
		else $error("monitor 2 ignores mapped signal");
endmodule
bind dpio_core dpio_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.mon_mapped(mon_mapped), .mon_signal_one(mon_signal_one), .mon_signal_two(mon_signal_two),
	.monitor_output_one(monitor_output_one), .monitor_output_two(monitor_output_two),
	.control_word(control_word), .trace_start(trace_start));
`default_nettype wire

// ==== verification/dpio_wiring.sv ====
`timescale 1ns/1ps
`default_nettype none
module dpio_wiring (
	input wire logic [2:0] lim_active, // Pre, pos, neg switch active
	input wire logic [2:0] sensor, // Trace, fast, meas sensor levels
	output var dpio_pkg::dpio_limit_t limit_pin, // To limit pins
	output var dpio_pkg::dpio_trig_t trig_pin // To trigger pins
);
	// Opener contacts: pin low while limit active
	assign limit_pin = {lim_active[2], ~lim_active[1:0]};
	assign trig_pin = sensor;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	typedef struct {logic w; logic [15:0] i; logic [4:0] e; logic [31:0] d; logic er;} dpio_row_t;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, ts;
	logic [22:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, axis = '0;
	logic [15:0] sp1 = 16'h8000, sp2 = 16'h7FFF, ms1 = 16'h4000, ms2 = '0, cw, mo1, mo2;
	logic [1:0] mmap = 2'b01;
	logic [2:0] lim = 3'b101, sen = '0;
	logic [19:0][7:0] dfree = {{19{8'hFF}}, 8'h0F}, dsig = 160'hF0;
	logic [23:0] outp;
	dpio_pkg::dpio_trig_t tpin;
	dpio_pkg::dpio_limit_t lpin;
	int n_errors = 0, samples_checked = 0, n_trace = 0;
	dpio_row_t rows[17] = '{
		'{0, dpio_pkg::IDX_MASK, 0, 0, 0},
		'{0, dpio_pkg::IDX_DONE, 0, 0, 0},
		'{0, dpio_pkg::IDX_AIN, 1, 32'hFFFF8000, 0},
		'{0, dpio_pkg::IDX_AIN, 2, 32'h7FFF, 0},
		'{0, dpio_pkg::IDX_LIMIT, 0, 32'h5, 0},
		'{1, dpio_pkg::IDX_DONE, 0, 32'h1, 1},
		'{0, 16'h1234, 0, 0, 1},
		'{1, dpio_pkg::IDX_DOUT, 1, 32'hA5, 0},
		'{0, dpio_pkg::IDX_DOUT, 1, 32'hF5, 0},
		'{1, dpio_pkg::IDX_DOUT, 4, 32'h1, 1},
		'{1, dpio_pkg::IDX_DOUT, 10, 32'h34, 0},
		'{1, dpio_pkg::IDX_DOUT, 11, 32'h12, 0},
		'{1, dpio_pkg::IDX_AOUT, 2, 32'hC000, 0},
		'{0, dpio_pkg::IDX_AOUT, 2, 32'hFFFFC000, 0},
		'{1, dpio_pkg::IDX_MODE, 3, 32'hFFFE, 0},
		'{1, dpio_pkg::IDX_MODE, 5, 32'hFFFF, 0},
		'{1, dpio_pkg::IDX_MASK, 0, 32'h15, 0}};
	dpio_wiring wires (.lim_active(lim), .sensor(sen), .limit_pin(lpin), .trig_pin(tpin));
	dpio_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .trig_pin(tpin), .limit_pin(lpin), .axis_position(axis),
		.setpoint_one(sp1), .setpoint_two(sp2), .mon_mapped(mmap), .mon_signal_one(ms1),
		.mon_signal_two(ms2), .dout_free(dfree), .dout_signal(dsig), .out_pins(outp),
		.control_word(cw), .monitor_output_one(mo1), .monitor_output_two(mo2), .trace_start(ts));
	// Clock and trace pulse count
	initial begin
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (ts === 1'b1) n_trace++;
	end
	task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
		samples_checked++;
		if (g !== x) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", s, x, g);
		end
	endtask
	// One bus transfer; d is write data or expected read data
	task automatic apb(input dpio_row_t r);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= r.w;
		paddr <= {r.e, r.i, 2'b00};
		pwdata <= r.d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk("pready", 32'h1, {31'h0, pready});
		chk("pslverr", {31'h0, r.er}, {31'h0, pslverr});
		if (!r.w) chk("prdata", r.d, prdata);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] i, input logic [4:0] e, input logic [31:0] d);
		apb('{1, i, e, d, 0});
	endtask
	task automatic rd(input logic [15:0] i, input logic [4:0] e, input logic [31:0] x);
		apb('{0, i, e, x, 0});
	endtask
	// Sensor change with position, then settle
	task automatic pin(input logic [2:0] v, input logic [31:0] p);
		axis <= p;
		sen <= v;
		repeat (6) @(posedge pclk);
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (5000) @(posedge pclk);
		n_errors++;
		wrap_up();
	end
	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[k]) apb(rows[k]);
		chk("out_pins", 32'hF5, {24'h0, outp[7:0]});
		chk("control_word", 32'h1234, {16'h0, cw});
		chk("monitor one", 32'h4000, {16'h0, mo1});
		chk("monitor two", 32'hC000, {16'h0, mo2});
		$display("table done");
		pin(3'b001, 32'h11);
		rd(dpio_pkg::IDX_DONE, 0, 32'h1);
		pin(3'b000, 32'h33);
		pin(3'b001, 32'h33);
		rd(dpio_pkg::IDX_POS1, 0, 32'h11);
		pin(3'b011, 32'h44);
		pin(3'b001, 32'h55);
		rd(dpio_pkg::IDX_POS1, 0, 32'h44);
		rd(dpio_pkg::IDX_POS2, 0, 32'h55);
		pin(3'b101, 32'h66);
		chk("trace count", 32'h0, n_trace);
		pin(3'b001, 32'h66);
		chk("trace count", 32'h1, n_trace);
		rd(dpio_pkg::IDX_DONE, 0, 32'h15);
		wr(dpio_pkg::IDX_MASK, 0, 32'h14);
		wr(dpio_pkg::IDX_MASK, 0, 32'h15);
		wr(dpio_pkg::IDX_MODE, 1, 32'hFFFD);
		rd(dpio_pkg::IDX_DONE, 0, 32'h14);
		pin(3'b000, 32'h77);
		rd(dpio_pkg::IDX_DONE, 0, 32'h14);
		pin(3'b001, 32'h88);
		rd(dpio_pkg::IDX_DONE, 0, 32'h15);
		rd(dpio_pkg::IDX_POS1, 0, 32'h77);
		$display("capture done");
		wr(dpio_pkg::IDX_IEN, 0, 32'h1);
		repeat (2) @(posedge pclk);
		chk("irq", 32'h1, {31'h0, irq});
		wr(dpio_pkg::IDX_IEN, 0, 32'h0);
		repeat (2) @(posedge pclk);
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(dpio_pkg::IDX_ICLR, 0, 32'h1);
		rd(dpio_pkg::IDX_ISTAT, 0, 32'h14);
		apb('{0, dpio_pkg::IDX_ICLR, 0, 0, 1});
		$display("interrupt done");
		wrap_up();
	end
endmodule
`default_nettype wire
